/* core/wec_top.sv */
// wakeup event counter: registers, pin edge select, tally and irq
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - irq enable set: irq raised when tally reaches threshold; clear: none
// - writing soft key bit one while it is zero adds exactly one event, debounced if on
// - debounce field gives n milliseconds; zero disables debouncing
// - eight-bit read-write threshold holds events needed before irq
// - any write to irq clear register clears irq unless irq is set in that cycle; reads return zero
// - tally readable as eight bits; irq clear also zeroes tally, or sets it to one if an event lands in that cycle
// - any write to tally clear register zeroes tally (one if an event lands in that cycle), data ignored
// - per-pin enable bits select pins feeding tally; port two five wide
// - per-pin polarity: zero counts rising, one counts falling
// - after reset all control fields are zero
module wec_top #(
   parameter int MS_CYCLES = wec_pkg::MS_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire wec_pkg::wec_bus_req_t bus,
   output logic [wec_pkg::DATA_W-1:0] rdata,
   input wire wec_pkg::wec_pins_t pins,
   output logic wake_irq
);
   function automatic logic wr_at(
      input wec_pkg::wec_bus_req_t b,
      input logic [wec_pkg::ADDR_W-1:0] off
   );
      return b.wr && (b.addr == off);
   endfunction

   function automatic logic [wec_pkg::DATA_W-1:0] zext8(
      input logic [7:0] v
   );
      return {8'h00, v};
   endfunction

   // control fields
   logic irq_en;
   logic soft_key_press;
   logic [wec_pkg::DEB_W-1:0] debounce_ms;
   logic [wec_pkg::CNT_W-1:0] threshold;
   wec_pkg::wec_pins_t pin_enable;
   wec_pkg::wec_pins_t pin_polarity;

   // state
   logic [wec_pkg::CNT_W-1:0] tally;
   wec_pkg::wec_pins_t pin_prev;
   logic prev_ok;

   // combinational
   logic [wec_pkg::PINS_W-1:0] rise;
   logic [wec_pkg::PINS_W-1:0] fall;
   logic [wec_pkg::PINS_W-1:0] pin_hit;
   logic pin_evt;
   logic soft_evt;
   logic raw_trig;
   logic qual;
   logic tally_clr;
   logic irq_clr;
   logic irq_set;
   logic [wec_pkg::CNT_W-1:0] next_tally;
   logic [wec_pkg::DATA_W-1:0] next_rdata;

   // control register
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         irq_en <= 1'b0;
         soft_key_press <= 1'b0;
         debounce_ms <= wec_pkg::DEB_RST;
      end else if (wr_at(bus, wec_pkg::ADDR_CTRL)) begin
         irq_en <= bus.wdata[wec_pkg::CTRL_IRQ_EN_BIT];
         soft_key_press <= bus.wdata[wec_pkg::CTRL_SOFT_BIT];
         debounce_ms <= bus.wdata[wec_pkg::CTRL_DEB_MSB:0];
      end
   end

   // threshold register
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         threshold <= wec_pkg::CNT_RST;
      end else if (wr_at(bus, wec_pkg::ADDR_THRESH)) begin
         threshold <= bus.wdata[wec_pkg::CNT_W-1:0];
      end
   end

   // per-pin enable registers
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pin_enable <= wec_pkg::PINS_RST;
      end else begin
         if (wr_at(bus, wec_pkg::ADDR_EN_P0)) begin
            pin_enable.p0 <= bus.wdata[7:0];
         end
         if (wr_at(bus, wec_pkg::ADDR_EN_P1)) begin
            pin_enable.p1 <= bus.wdata[7:0];
         end
         if (wr_at(bus, wec_pkg::ADDR_EN_P2)) begin
            pin_enable.p2 <= bus.wdata[4:0];
         end
         if (wr_at(bus, wec_pkg::ADDR_EN_P3)) begin
            pin_enable.p3 <= bus.wdata[7:0];
         end
         if (wr_at(bus, wec_pkg::ADDR_EN_P4)) begin
            pin_enable.p4 <= bus.wdata[7:0];
         end
      end
   end

   // per-pin polarity registers
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pin_polarity <= wec_pkg::PINS_RST;
      end else begin
         if (wr_at(bus, wec_pkg::ADDR_POL_P0)) begin
            pin_polarity.p0 <= bus.wdata[7:0];
         end
         if (wr_at(bus, wec_pkg::ADDR_POL_P1)) begin
            pin_polarity.p1 <= bus.wdata[7:0];
         end
         if (wr_at(bus, wec_pkg::ADDR_POL_P2)) begin
            pin_polarity.p2 <= bus.wdata[4:0];
         end
         if (wr_at(bus, wec_pkg::ADDR_POL_P3)) begin
            pin_polarity.p3 <= bus.wdata[7:0];
         end
         if (wr_at(bus, wec_pkg::ADDR_POL_P4)) begin
            pin_polarity.p4 <= bus.wdata[7:0];
         end
      end
   end

   // previous pin levels; first sample after reset only primes
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pin_prev <= wec_pkg::PINS_RST;
         prev_ok <= 1'b0;
      end else begin
         pin_prev <= pins;
         prev_ok <= 1'b1;
      end
   end

   // edge select per pin
   always_comb begin
      rise = pins & ~pin_prev;
      fall = ~pins & pin_prev;
      pin_hit = pin_enable & ((~pin_polarity & rise)
         | (pin_polarity & fall));
   end

   // a held soft key masks real keys until software drops it
   assign pin_evt = prev_ok && (|pin_hit) && !soft_key_press;

   // soft key fires on the zero-to-one write only
   assign soft_evt = wr_at(bus, wec_pkg::ADDR_CTRL)
      && bus.wdata[wec_pkg::CTRL_SOFT_BIT]
      && !soft_key_press;

   assign raw_trig = pin_evt || soft_evt;

   wec_debounce #(
      .MS_CYCLES(MS_CYCLES)
   ) u_debounce (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .trig(raw_trig),
      .deb_ms(debounce_ms),
      .pulse(qual)
   );

   assign irq_clr = wr_at(bus, wec_pkg::ADDR_IRQ_CLR);
   assign tally_clr = wr_at(bus, wec_pkg::ADDR_TALLY_CLR)
      || irq_clr;

   // an event in the clearing cycle still counts as one
   always_comb begin
      if (qual && tally_clr) begin
         next_tally = 8'h01;
      end else if (qual) begin
         next_tally = tally + 8'h01;
      end else if (tally_clr) begin
         next_tally = wec_pkg::CNT_RST;
      end else begin
         next_tally = tally;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         tally <= wec_pkg::CNT_RST;
      end else begin
         tally <= next_tally;
      end
   end

   assign irq_set = qual && irq_en
      && (next_tally == threshold);

   // set wins over a simultaneous clear
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wake_irq <= 1'b0;
      end else if (irq_set) begin
         wake_irq <= 1'b1;
      end else if (irq_clr) begin
         wake_irq <= 1'b0;
      end
   end

   // read mux; write-only and unmapped words read zero
   always_comb begin
      next_rdata = wec_pkg::READ_ZERO;
      if (bus.rd) begin
         unique case (bus.addr)
            wec_pkg::ADDR_CTRL: begin
               next_rdata = zext8({irq_en, soft_key_press,
                  debounce_ms});
            end
            wec_pkg::ADDR_THRESH: begin
               next_rdata = zext8(threshold);
            end
            wec_pkg::ADDR_TALLY: begin
               next_rdata = zext8(tally);
            end
            wec_pkg::ADDR_EN_P0: begin
               next_rdata = zext8(pin_enable.p0);
            end
            wec_pkg::ADDR_EN_P1: begin
               next_rdata = zext8(pin_enable.p1);
            end
            wec_pkg::ADDR_EN_P2: begin
               next_rdata = zext8({3'h0, pin_enable.p2});
            end
            wec_pkg::ADDR_EN_P3: begin
               next_rdata = zext8(pin_enable.p3);
            end
            wec_pkg::ADDR_EN_P4: begin
               next_rdata = zext8(pin_enable.p4);
            end
            wec_pkg::ADDR_POL_P0: begin
               next_rdata = zext8(pin_polarity.p0);
            end
            wec_pkg::ADDR_POL_P1: begin
               next_rdata = zext8(pin_polarity.p1);
            end
            wec_pkg::ADDR_POL_P2: begin
               next_rdata = zext8({3'h0, pin_polarity.p2});
            end
            wec_pkg::ADDR_POL_P3: begin
               next_rdata = zext8(pin_polarity.p3);
            end
            wec_pkg::ADDR_POL_P4: begin
               next_rdata = zext8(pin_polarity.p4);
            end
            default: begin
               next_rdata = wec_pkg::READ_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rdata <= wec_pkg::READ_ZERO;
      end else begin
         rdata <= next_rdata;
      end
   end

   sequence irq_clr_s;
      irq_clr && !irq_set;
   endsequence

   sequence rd_at_s(logic [wec_pkg::ADDR_W-1:0] off);
      bus.rd && bus.addr == off;
   endsequence

   irq_clear_a: assert property (@(posedge clk_sys)
      disable iff (!rstn)
      irq_clr_s |=> !wake_irq && tally == {7'h00, $past(qual)})
      else $error("irq clear write did not clear irq and tally");

   clr_reads_zero_a: assert property (@(posedge clk_sys)
      disable iff (!rstn)
      rd_at_s(wec_pkg::ADDR_IRQ_CLR) |=> rdata == 16'h0000)
      else $error("irq clear register read nonzero");

   tally_read_a: assert property (@(posedge clk_sys)
      disable iff (!rstn)
      rd_at_s(wec_pkg::ADDR_TALLY)
      |=> rdata == {8'h00, $past(tally)})
      else $error("tally read does not match tally");

   tally_clear_a: assert property (@(posedge clk_sys)
      disable iff (!rstn)
      wr_at(bus, wec_pkg::ADDR_TALLY_CLR) && !qual |=> tally == 8'h00)
      else $error("tally clear write did not zero tally");

   count_step_a: assert property (@(posedge clk_sys)
      disable iff (!rstn)
      qual && !tally_clr |=> tally == $past(tally) + 8'h01)
      else $error("qualified event did not add exactly one");

   irq_off_a: assert property (@(posedge clk_sys)
      disable iff (!rstn)
      !irq_en && !wake_irq ##1 !irq_en |-> !wake_irq)
      else $error("irq raised while disabled");

   irq_reach_a: assert property (@(posedge clk_sys)
      disable iff (!rstn)
      qual && irq_en && !tally_clr && tally + 8'h01 == threshold
      |=> wake_irq)
      else $error("irq not raised on reaching threshold");

   soft_press_a: assert property (@(posedge clk_sys)
      disable iff (!rstn)
      soft_evt && debounce_ms == 6'h00
      && u_debounce.state == wec_pkg::DB_IDLE
      |=> qual ##1 tally != $past(tally, 2))
      else $error("soft key write did not count one event");

   edge_pol_a: assert property (@(posedge clk_sys)
      disable iff (!rstn)
      prev_ok && !soft_key_press && pin_enable.p0[0]
      && pin_polarity.p0[0] && !pins.p0[0] && pin_prev.p0[0]
      |-> raw_trig)
      else $error("falling edge on enabled pin not seen");

   irq_hold_a: assert property (@(posedge clk_sys)
      disable iff (!rstn)
      wake_irq && !irq_clr |=> wake_irq)
      else $error("wakeup irq dropped without a clear write");

   tally_hold_a: assert property (@(posedge clk_sys)
      disable iff (!rstn)
      !qual && !tally_clr |=> tally == $past(tally))
      else $error("tally moved without a qualified event");

   pin_mask_a: assert property (@(posedge clk_sys)
      disable iff (!rstn)
      pin_enable == wec_pkg::PINS_RST && !soft_evt |-> !raw_trig)
      else $error("trigger seen with every pin excluded");
endmodule // wec_top
`default_nettype wire

/* core/wec_pkg.sv */
// package: wakeup event counter map, fields, timing and carriers
package wec_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 32;
   localparam int CNT_W = 8;
   localparam int DEB_W = 6;
   localparam int PINS_W = 37;

   localparam logic [ADDR_W-1:0] ADDR_CTRL = 32'h5000_0100;
   localparam logic [ADDR_W-1:0] ADDR_THRESH = 32'h5000_0102;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR = 32'h5000_0104;
   localparam logic [ADDR_W-1:0] ADDR_TALLY = 32'h5000_0106;
   localparam logic [ADDR_W-1:0] ADDR_TALLY_CLR = 32'h5000_0108;
   localparam logic [ADDR_W-1:0] ADDR_EN_P0 = 32'h5000_010A;
   localparam logic [ADDR_W-1:0] ADDR_EN_P1 = 32'h5000_010C;
   localparam logic [ADDR_W-1:0] ADDR_EN_P2 = 32'h5000_010E;
   localparam logic [ADDR_W-1:0] ADDR_EN_P3 = 32'h5000_0110;
   localparam logic [ADDR_W-1:0] ADDR_EN_P4 = 32'h5000_0112;
   localparam logic [ADDR_W-1:0] ADDR_POL_P0 = 32'h5000_0114;
   localparam logic [ADDR_W-1:0] ADDR_POL_P1 = 32'h5000_0116;
   localparam logic [ADDR_W-1:0] ADDR_POL_P2 = 32'h5000_0118;
   localparam logic [ADDR_W-1:0] ADDR_POL_P3 = 32'h5000_011A;
   localparam logic [ADDR_W-1:0] ADDR_POL_P4 = 32'h5000_011C;

   localparam int CTRL_IRQ_EN_BIT = 7;
   localparam int CTRL_SOFT_BIT = 6;
   localparam int CTRL_DEB_MSB = 5;

   localparam logic [DEB_W-1:0] DEB_RST = 6'h00;
   localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
   localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;

   localparam int CLK_PERIOD_NS = 25;
   localparam int DEB_UNIT_NS = 1000000;
   localparam int MS_CYCLES =
      (DEB_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } wec_bus_req_t;

   typedef struct packed {
      logic [7:0] p4;
      logic [7:0] p3;
      logic [4:0] p2;
      logic [7:0] p1;
      logic [7:0] p0;
   } wec_pins_t;

   localparam wec_pins_t PINS_RST = 37'h00_0000_0000;

   typedef enum logic {
      DB_IDLE,
      DB_WAIT
   } wec_db_state_t;
endpackage

/* core/wec_debounce.sv */
// debounce filter: passes a trigger after n milliseconds of hold-off
`timescale 1ns/1ps
`default_nettype none
module wec_debounce #(
   parameter int MS_CYCLES = wec_pkg::MS_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic trig,
   input wire logic [wec_pkg::DEB_W-1:0] deb_ms,
   output logic pulse
);
   localparam int DIV_W = $clog2(MS_CYCLES + 1);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_CYCLES - 1);

   wec_pkg::wec_db_state_t state;
   logic [DIV_W-1:0] div;
   logic [wec_pkg::DEB_W-1:0] ms_left;
   logic ms_tick;

   assign ms_tick = (state == wec_pkg::DB_WAIT) && (div == DIV_LAST);

   // millisecond divider, restarted on every accepted trigger
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         div <= '0;
      end else if (state == wec_pkg::DB_IDLE || ms_tick) begin
         div <= '0;
      end else begin
         div <= div + 1'b1;
      end
   end

   // bounces inside the hold-off window are swallowed
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state <= wec_pkg::DB_IDLE;
         ms_left <= wec_pkg::DEB_RST;
         pulse <= 1'b0;
      end else begin
         pulse <= 1'b0;
         unique case (state)
            wec_pkg::DB_IDLE: begin
               if (trig && deb_ms == wec_pkg::DEB_RST) begin
                  pulse <= 1'b1;
               end else if (trig) begin
                  ms_left <= deb_ms;
                  state <= wec_pkg::DB_WAIT;
               end
            end
            wec_pkg::DB_WAIT: begin
               if (ms_tick && ms_left == 6'h01) begin
                  pulse <= 1'b1;
                  state <= wec_pkg::DB_IDLE;
               end else if (ms_tick) begin
                  ms_left <= ms_left - 6'h01;
               end
            end
         endcase
      end
   end

   sequence idle_trig_s;
      state == wec_pkg::DB_IDLE && trig;
   endsequence

   zero_pass_a: assert property (@(posedge clk_sys)
      disable iff (!rstn)
      idle_trig_s and deb_ms == 6'h00 |=> pulse)
      else $error("debounce off but trigger not passed");

   hold_off_a: assert property (@(posedge clk_sys)
      disable iff (!rstn)
      (idle_trig_s and deb_ms != 6'h00)
      or (state == wec_pkg::DB_WAIT && !(ms_tick && ms_left == 6'h01))
      |=> !pulse)
      else $error("debounced trigger passed too early");
endmodule // wec_debounce
`default_nettype wire

/* verification/wec_keys.sv */
// far-side model: wake sources on the port pins
`timescale 1ns/1ps
`default_nettype none
module wec_keys (
   input wire logic clk_sys,
   output var wec_pkg::wec_pins_t pins
);
   initial pins = wec_pkg::PINS_RST;

   // levels change just after an edge, held until the next call
   task automatic put(input logic [36:0] v);
      @(posedge clk_sys);
      pins <= v;
   endtask
endmodule // wec_keys
`default_nettype wire

/* verification/tb_top.sv */
// self-checking bench for the wakeup event counter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int MS = 4;
   typedef struct {
      logic [31:0] a;
      logic [15:0] d;
      logic [15:0] e;
   } wec_row_t;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   wec_pkg::wec_bus_req_t bus = '0;
   logic [15:0] rdata;
   wec_pkg::wec_pins_t pins;
   logic wake_irq;
   logic [36:0] pv = '0;
   logic [15:0] v;
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;
   wec_row_t rows[16] = '{
      '{wec_pkg::ADDR_CTRL, 16'hFF80, 16'h0080},
      '{wec_pkg::ADDR_THRESH, 16'hFFFF, 16'h00FF},
      '{wec_pkg::ADDR_IRQ_CLR, 16'hFFFF, 16'h0000},
      '{wec_pkg::ADDR_TALLY, 16'hFFFF, 16'h0000},
      '{wec_pkg::ADDR_TALLY_CLR, 16'hFFFF, 16'h0000},
      '{wec_pkg::ADDR_EN_P0, 16'hFFFF, 16'h00FF},
      '{wec_pkg::ADDR_EN_P1, 16'hFFFF, 16'h00FF},
      '{wec_pkg::ADDR_EN_P2, 16'hFFFF, 16'h001F},
      '{wec_pkg::ADDR_EN_P3, 16'hFFFF, 16'h00FF},
      '{wec_pkg::ADDR_EN_P4, 16'hFFFF, 16'h00FF},
      '{wec_pkg::ADDR_POL_P0, 16'hFFFF, 16'h00FF},
      '{wec_pkg::ADDR_POL_P1, 16'hFFFF, 16'h00FF},
      '{wec_pkg::ADDR_POL_P2, 16'hFFFF, 16'h001F},
      '{wec_pkg::ADDR_POL_P3, 16'hFFFF, 16'h00FF},
      '{wec_pkg::ADDR_POL_P4, 16'hFFFF, 16'h00FF},
      '{32'h5000_011E, 16'hFFFF, 16'h0000}
   };

   always #12.5 clk_sys = ~clk_sys;

   wec_top #(.MS_CYCLES(MS)) wec_top_inst (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .bus(bus),
      .rdata(rdata),
      .pins(pins),
      .wake_irq(wake_irq)
   );

   wec_keys wec_keys_inst (
      .clk_sys(clk_sys),
      .pins(pins)
   );

   task automatic check(input string nm, input logic [15:0] s,
                        input logic [15:0] e);
      n_tests++;
      if (s !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus.wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rdchk(input string nm, input logic [31:0] a,
                        input logic [15:0] e);
      @(posedge clk_sys);
      bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus.rd <= 1'b0;
      #1 v = rdata;
      check(nm, v, e);
   endtask

   task automatic pulse(input int k);
      pv[k] = ~pv[k];
      wec_keys_inst.put(pv);
      tick(3);
      pv[k] = ~pv[k];
      wec_keys_inst.put(pv);
      tick(3);
   endtask

   task automatic irqchk(input logic e);
      check("wake_irq", {15'h0000, wake_irq}, {15'h0000, e});
   endtask

   task automatic summarize;
      if (n_fail == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         summarize();
      end
   end

   initial begin
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      foreach (rows[i]) begin
         rdchk("reset value", rows[i].a, 16'h0000);
         wr(rows[i].a, rows[i].d);
         rdchk("readback", rows[i].a, rows[i].e);
      end
      // all pins on, falling edges first
      for (int i = 0; i < 37; i++) pulse(i);
      rdchk("tally fall", wec_pkg::ADDR_TALLY, 16'h0025);
      for (int i = 0; i < 5; i++) begin
         wr(wec_pkg::ADDR_POL_P0 + 32'(2 * i), 16'h0000);
      end
      for (int i = 0; i < 37; i++) pulse(i);
      rdchk("tally rise", wec_pkg::ADDR_TALLY, 16'h004A);
      wr(wec_pkg::ADDR_POL_P4, 16'h0080);
      pv[36] = 1'b1;
      wec_keys_inst.put(pv);
      tick(3);
      rdchk("rise ignored", wec_pkg::ADDR_TALLY, 16'h004A);
      pv[36] = 1'b0;
      wec_keys_inst.put(pv);
      tick(3);
      rdchk("fall counted", wec_pkg::ADDR_TALLY, 16'h004B);
      wr(wec_pkg::ADDR_EN_P1, 16'h0000);
      pulse(8);
      rdchk("excluded pin", wec_pkg::ADDR_TALLY, 16'h004B);
      wr(wec_pkg::ADDR_TALLY_CLR, 16'h1234);
      rdchk("tally clear", wec_pkg::ADDR_TALLY, 16'h0000);
      // soft key held high blocks further presses
      wr(wec_pkg::ADDR_CTRL, 16'h0040);
      tick(3);
      wr(wec_pkg::ADDR_CTRL, 16'h0040);
      tick(3);
      pulse(0);
      rdchk("soft once", wec_pkg::ADDR_TALLY, 16'h0001);
      wr(wec_pkg::ADDR_CTRL, 16'h0000);
      wr(wec_pkg::ADDR_CTRL, 16'h0040);
      tick(3);
      rdchk("soft rearm", wec_pkg::ADDR_TALLY, 16'h0002);
      wr(wec_pkg::ADDR_THRESH, 16'h0003);
      wr(wec_pkg::ADDR_CTRL, 16'h0080);
      wr(wec_pkg::ADDR_TALLY_CLR, 16'h0000);
      pulse(0);
      pulse(0);
      irqchk(1'b0);
      pulse(0);
      irqchk(1'b1);
      wr(wec_pkg::ADDR_IRQ_CLR, 16'hA5A5);
      tick(1);
      irqchk(1'b0);
      rdchk("tally on irq clear", wec_pkg::ADDR_TALLY, 16'h0000);
      wr(wec_pkg::ADDR_CTRL, 16'h0000);
      wr(wec_pkg::ADDR_THRESH, 16'h0001);
      pulse(0);
      irqchk(1'b0);
      // two ms hold-off; second edge inside it is dropped
      wr(wec_pkg::ADDR_CTRL, 16'h0002);
      pv[1] = 1'b1;
      wec_keys_inst.put(pv);
      tick(2);
      pv[2] = 1'b1;
      wec_keys_inst.put(pv);
      tick(1);
      rdchk("debounce wait", wec_pkg::ADDR_TALLY, 16'h0001);
      tick(10);
      rdchk("debounce done", wec_pkg::ADDR_TALLY, 16'h0002);
      wr(wec_pkg::ADDR_THRESH, 16'h0003);
      wr(wec_pkg::ADDR_CTRL, 16'h0080);
      pulse(0);
      irqchk(1'b1);
      @(posedge clk_sys);
      rstn <= 1'b0;
      tick(2);
      irqchk(1'b0);
      rstn <= 1'b1;
      rdchk("ctrl after reset", wec_pkg::ADDR_CTRL, 16'h0000);
      rdchk("tally after reset", wec_pkg::ADDR_TALLY, 16'h0000);
      summarize();
   end
endmodule // tb_top
`default_nettype wire
